// ---- bench/spi_host_model.sv ----
`timescale 1ns/100ps

module spi_host_model #(
    parameter int HALF = 6
) (
    // Clock
    input  wire logic sys_clk_i,
    // Device side
    input  wire logic so_i,
    input  wire logic so_oe_i,
    output logic      sck_o,
    output logic      cs_n_o,
    output logic      si_o
);
    flash_param_pkg::byte_type rx_q [0:31];
    int                        oe_ones;

    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        si_o   = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    // Half period of 6 system clocks keeps well inside the 4-cycle minimum
    task automatic cyc(input logic b);
        sck_o = 1'b0;
        si_o  = b;
        tick(HALF);
        sck_o = 1'b1;
        tick(HALF);
    endtask

    // A nonzero stop_at drops select after that many serial clocks
    task automatic read(input logic [7:0] op, input logic [23:0] adr, input int nbytes,
                        input logic cpol, input int stop_at);
        logic [39:0] hdr;
        int          n;
        hdr     = {op, adr, 8'hFF};
        oe_ones = 0;
        n       = 0;
        sck_o   = cpol;
        tick(2);
        cs_n_o  = 1'b0;
        tick(2);
        for (int i = 39; i >= 0 && (stop_at == 0 || n < stop_at); i--) begin
            cyc(hdr[i]);
            n++;
        end
        for (int k = 0; k < nbytes && stop_at == 0; k++) begin
            for (int j = 7; j >= 0; j--) begin
                sck_o = 1'b0;
                si_o  = ~si_o;
                tick(HALF);
                // A released line reads high through its pull-up
                rx_q[k][j] = (so_oe_i === 1'b1) ? so_i : 1'b1;
                if (so_oe_i === 1'b1) begin
                    oe_ones++;
                end
                sck_o = 1'b1;
                tick(HALF);
            end
        end
        sck_o  = cpol;
        tick(HALF);
        cs_n_o = 1'b1;
        si_o   = ~si_o;
        tick(6);
    endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/100ps

module tb;
    logic        sys_clk_i;
    logic        rstn_i;
    logic        ddr_variant_i;
    logic        sck;
    logic        cs_n;
    logic        si;
    logic        so;
    logic        so_oe;
    logic [31:0] rnd_q;
    logic [23:0] nxt;
    int          err_count;
    int          cmp_count;

    flash_param_discovery_rom i_flash_param_discovery_rom (
        .sys_clk_i    (sys_clk_i),
        .rstn_i       (rstn_i),
        .spi_sck_i    (sck),
        .spi_cs_n_i   (cs_n),
        .spi_si_i     (si),
        .spi_so_o     (so),
        .spi_so_oe_o  (so_oe),
        .ddr_variant_i(ddr_variant_i)
    );

    spi_host_model i_spi_host_model (
        .sys_clk_i(sys_clk_i),
        .so_i     (so),
        .so_oe_i  (so_oe),
        .sck_o    (sck),
        .cs_n_o   (cs_n),
        .si_o     (si)
    );

    always #25 sys_clk_i = ~sys_clk_i;

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Wrapped offset zero answers at 108Eh, so 1090h lands on offset two
    function automatic logic [7:0] exp_byte(input logic [23:0] a, input logic ddr);
        logic [23:0] o;
        o = a - 24'h00108E;
        case (o)
            24'h000000: return 8'hA5;
            24'h000001: return 8'h88;
            24'h000002: return 8'hE7;
            24'h000003: return 8'hFF;
            24'h000004: return ddr ? 8'hBA : 8'hB2;
            24'h000005: return 8'hFF;
            24'h000009: return 8'h1F;
            24'h00000A: return 8'h48;
            24'h00000B: return 8'hEB;
            default:    return 8'hFF;
        endcase
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic rd(input logic [23:0] a, input int n, input logic cpol);
        i_spi_host_model.read(8'h5A, a, n, cpol, 0);
        for (int k = 0; k < n; k++) begin
            check({24'h0, i_spi_host_model.rx_q[k]}, {24'h0, exp_byte(a + 24'(k), ddr_variant_i)});
        end
        check(i_spi_host_model.oe_ones, 8 * n);
        check({31'h0, so_oe}, 32'h0);
    endtask

    task automatic settle();
        repeat (4) @(posedge sys_clk_i);
        #1;
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk_i);
        err_count++;
        stop_test();
    end

    initial begin
        sys_clk_i     = 1'b0;
        rstn_i        = 1'b0;
        ddr_variant_i = 1'b0;
        err_count     = 0;
        cmp_count     = 0;
        rnd_q         = 32'h34bb;
        repeat (20) @(posedge sys_clk_i);
        #1;
        check({30'h0, so, so_oe}, 32'h0);
        rstn_i = 1'b1;
        settle();
        // Whole first section, variant 0 in clock mode 0 and variant 1 in clock mode 3
        for (int v = 0; v < 2; v++) begin
            ddr_variant_i = v[0];
            settle();
            rd(24'h00108E, 16, v[0]);
        end
        // Host walks to the next parameter from the length byte
        rd(24'h00108F, 1, 1'b0);
        nxt = 24'h00108F + {16'h0, i_spi_host_model.rx_q[0]} + 24'h000001;
        check({8'h0, nxt}, 32'h00001118);
        rd(nxt - 24'h000001, 2, 1'b1);
        rd(24'h001090, 3, 1'b0);
        rd(24'hFFFFFF, 2, 1'b0);
        // Foreign opcode leaves the output undriven
        i_spi_host_model.read(8'hA5, 24'h00108E, 2, 1'b0, 0);
        check(i_spi_host_model.oe_ones, 32'h0);
        check({24'h0, i_spi_host_model.rx_q[0]}, 32'h000000FF);
        // Select dropped mid-address, then a clean frame
        i_spi_host_model.read(8'h5A, 24'h00108E, 0, 1'b0, 20);
        check({31'h0, so_oe}, 32'h0);
        rd(24'h00108E, 2, 1'b0);
        for (int r = 0; r < 12; r++) begin
            rnd_q         = xs(rnd_q);
            ddr_variant_i = rnd_q[31];
            settle();
            rd(24'h001080 + {18'h0, rnd_q[5:0]}, 1 + int'(rnd_q[10:8]), rnd_q[12]);
        end
        // Reset in mid-run clears the output and the next frame is whole
        rstn_i = 1'b0;
        settle();
        check({30'h0, so, so_oe}, 32'h0);
        rstn_i = 1'b1;
        settle();
        rd(24'h001092, 4, 1'b1);
        stop_test();
    end
endmodule

// ---- hdl/flash_param_discovery_rom.sv ----
`timescale 1ns/100ps
`include "flash_param_regs.svh"

module flash_param_discovery_rom (
    // Clock and reset
    input  wire logic sys_clk_i,
    input  wire logic rstn_i,
    // Serial read port, clock modes 0 and 3
    input  wire logic spi_sck_i,
    input  wire logic spi_cs_n_i,
    input  wire logic spi_si_i,
    output logic      spi_so_o,
    output logic      spi_so_oe_o,
    // Part variant strap, high on the double data rate part
    input  wire logic ddr_variant_i
);

    // ID and length bytes sit just below the first basic table byte
    localparam logic [23:0] BASE_ADDR = `BFT_SFDP_ADDR - `WRAP_SHIFT;
    localparam logic [23:0] SPAN      = {16'h0000, `PRM_LEN_VAL} + `WRAP_SHIFT;

    logic [3:0]                      pins_s;
    flash_param_pkg::xfer_state_type state_q;
    flash_param_pkg::xfer_state_type state_d;
    logic [4:0]                      cnt_q;
    logic [4:0]                      cnt_d;
    logic [7:0]                      cmd_q;
    flash_param_pkg::addr_type       addr_q;
    flash_param_pkg::byte_type       byte_q;
    logic                            sck_prev_q;
    logic                            so_q;
    logic                            oe_q;

    rom_rd_if rd_bus ();

    // Pins come from the host's domain; SCK must stay well below the system clock
    pin_sync #(
        .W       (4),
        .RST_VAL (4'h2)
    ) u_pin_sync (
        .clk_i  (sys_clk_i),
        .rstn_i (rstn_i),
        .d_i    ({ddr_variant_i, spi_si_i, spi_cs_n_i, spi_sck_i}),
        .q_o    (pins_s)
    );

    param_rom u_param_rom (
        .clk_i  (sys_clk_i),
        .rstn_i (rstn_i),
        .bus    (rd_bus.store)
    );

    wire logic sck_s   = pins_s[0];
    wire logic cs_n_s  = pins_s[1];
    wire logic si_s    = pins_s[2];
    wire logic ddr_s   = pins_s[3];

    // Edges only count inside a frame
    wire logic rise    = ~cs_n_s & sck_s & ~sck_prev_q;
    wire logic fall    = ~cs_n_s & ~sck_s & sck_prev_q;

    // Idle also shifts so a first SCK edge right after select is not lost
    wire logic in_cmd   = (state_q == flash_param_pkg::ST_IDLE) | (state_q == flash_param_pkg::ST_CMD);
    wire logic in_addr  = (state_q == flash_param_pkg::ST_ADDR);
    wire logic in_dummy = (state_q == flash_param_pkg::ST_DUMMY);
    wire logic in_data  = (state_q == flash_param_pkg::ST_DATA);

    wire logic [7:0] cmd_next  = {cmd_q[6:0], si_s};
    wire logic       cmd_done  = rise & in_cmd & (cnt_q == `CMD_LAST);
    wire logic       cmd_ok    = (cmd_next == `RD_OPCODE);
    wire logic       addr_done = rise & in_addr & (cnt_q == `ADDR_LAST);
    wire logic       dummy_done = rise & in_dummy & (cnt_q == `DUMMY_LAST);
    wire logic       byte_done = fall & in_data & (cnt_q[2:0] == `BYTE_LAST);

    wire logic [23:0] ofs_w = addr_q - BASE_ADDR;
    wire logic        hit   = (addr_q >= BASE_ADDR) & (ofs_w < SPAN);

    assign rd_bus.rd_en   = ~in_cmd;
    assign rd_bus.hit     = hit;
    assign rd_bus.ofs     = ofs_w[7:0];
    assign rd_bus.ddr_sel = ddr_s;

    always_comb begin
        state_d = state_q;
        if (cs_n_s) begin
            state_d = flash_param_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                flash_param_pkg::ST_IDLE: begin
                    state_d = flash_param_pkg::ST_CMD;
                end
                flash_param_pkg::ST_CMD: begin
                    if (cmd_done) begin
                        state_d = cmd_ok ? flash_param_pkg::ST_ADDR : flash_param_pkg::ST_SKIP;
                    end
                end
                flash_param_pkg::ST_ADDR: begin
                    if (addr_done) begin
                        state_d = flash_param_pkg::ST_DUMMY;
                    end
                end
                flash_param_pkg::ST_DUMMY: begin
                    if (dummy_done) begin
                        state_d = flash_param_pkg::ST_DATA;
                    end
                end
                flash_param_pkg::ST_DATA: begin
                    state_d = flash_param_pkg::ST_DATA;
                end
                flash_param_pkg::ST_SKIP: begin
                    state_d = flash_param_pkg::ST_SKIP;
                end
                default: begin
                    state_d = flash_param_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Cleared at every phase boundary and every byte, counts rises before data, falls during it
    assign cnt_d = (cs_n_s | cmd_done | addr_done | dummy_done | byte_done) ? 5'h00 :
                   ((rise & ~in_data) | (fall & in_data)) ? cnt_q + 5'h01 : cnt_q;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q    <= flash_param_pkg::ST_IDLE;
            cnt_q      <= 5'h00;
            sck_prev_q <= 1'h0;
        end else begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            sck_prev_q <= sck_s;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_q <= 8'h00;
        end else if (rise & in_cmd) begin
            cmd_q <= cmd_next;
        end
    end

    // The store answers one cycle after the address settles, long before the next SCK edge
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_q <= 24'h000000;
            byte_q <= `PARAM_FILL;
        end else if (rise & in_addr) begin
            addr_q <= {addr_q[22:0], si_s};
        end else if (dummy_done | byte_done) begin
            addr_q <= addr_q + 24'h000001;
            byte_q <= rd_bus.rdata;
        end
    end

    // Output changes on falling SCK so the host samples it stable on the rise
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            so_q <= 1'h0;
            oe_q <= 1'h0;
        end else begin
            if (fall & in_data) begin
                so_q <= byte_q[~cnt_q[2:0]];
            end
            oe_q <= (state_d == flash_param_pkg::ST_DATA);
        end
    end

    assign spi_so_o    = so_q;
    assign spi_so_oe_o = oe_q;

    default clocking cb @(posedge sys_clk_i);
    endclocking

    default disable iff (!rstn_i);

    a_id_byte : assert property (
        rd_bus.rd_en && rd_bus.hit && rd_bus.ofs == `OFS_ID |=> rd_bus.rdata == `PRM_ID_VAL
    ) else $error("Identifier byte is wrong");

    a_length_byte : assert property (
        rd_bus.rd_en && addr_q == BASE_ADDR + 24'h000001 |=> rd_bus.rdata == `PRM_LEN_VAL
    ) else $error("Length byte is wrong");

    a_table_start : assert property (
        rd_bus.rd_en && addr_q == `BFT_SFDP_ADDR |=> rd_bus.rdata[7:5] == `CAPS_UNUSED
            && rd_bus.rdata[2] == `CAPS_BUF_GT64
    ) else $error("First table byte not at its address");

    a_caps_fields : assert property (
        rd_bus.rd_en && rd_bus.hit && rd_bus.ofs == `OFS_CAPS
            |=> rd_bus.rdata[4:3] == `CAPS_SR_NV06 && rd_bus.rdata[1:0] == `CAPS_4K_NONE
    ) else $error("Capability byte fields wrong");

    a_no_4k_opcode : assert property (
        rd_bus.rd_en && rd_bus.hit && rd_bus.ofs == `OFS_ERASE4K |=> rd_bus.rdata == `ERASE4K_OPC
    ) else $error("Erase opcode byte wrong");

    a_ddr_flag : assert property (
        rd_bus.rd_en && rd_bus.hit && rd_bus.ofs == `OFS_DW1B2
            |=> rd_bus.rdata[`DW1_DDR_BIT] == $past(ddr_s)
    ) else $error("Double data rate flag does not follow the variant");

    a_addr_modes : assert property (
        rd_bus.rd_en && rd_bus.hit && rd_bus.ofs == `OFS_DW1B2 |=> rd_bus.rdata[2:1] == `DW1_ADDR_MODE
    ) else $error("Address byte mode field wrong");

    a_read_types : assert property (
        rd_bus.rd_en && rd_bus.hit && rd_bus.ofs == `OFS_DW1B2
            |=> {rd_bus.rdata[7:4], rd_bus.rdata[0]} == {`DW1_BIT23, `DW1_QOUT, `DW1_QIO, `DW1_DIO, `DW1_DOUT}
    ) else $error("Read type support bits wrong");

    a_dw1_top : assert property (
        rd_bus.rd_en && rd_bus.hit && rd_bus.ofs == `OFS_DW1B3 |=> rd_bus.rdata == `DW1_TOP
    ) else $error("Dword one top byte wrong");

    a_density_msb : assert property (
        rd_bus.rd_en && rd_bus.hit && rd_bus.ofs == `OFS_DEN3 |=> rd_bus.rdata == 8'h1F
    ) else $error("Density top byte wrong");

    a_qio_fields : assert property (
        rd_bus.rd_en && rd_bus.hit && rd_bus.ofs == `OFS_QIO_CYC ##1 rd_bus.rd_en && addr_q == $past(addr_q)
            |=> rd_bus.rdata == {`QIO_MODE_CYC, `QIO_DUMMY_CYC}
    ) else $error("Quad I/O cycle byte wrong");

    a_qout_fields : assert property (
        rd_bus.rd_en && rd_bus.hit && rd_bus.ofs == `OFS_QOUT_CYC |=> rd_bus.rdata == {`QOUT_MODE_CYC, `QOUT_DUMMY_CYC}
    ) else $error("Quad output cycle byte not all ones");

    a_byte_advance : assert property (
        byte_done |=> addr_q == $past(addr_q) + 24'h000001 && cnt_q == 5'h00
    ) else $error("Address did not advance after a byte");

    a_frame_release : assert property (
        cs_n_s |=> !spi_so_oe_o && state_q == flash_param_pkg::ST_IDLE
    ) else $error("Output still driven after deselect");

    a_wrap_offset : assert property (
        addr_q == `BFT_SFDP_ADDR |-> rd_bus.hit && rd_bus.ofs == `OFS_CAPS
    ) else $error("Wrapped offset does not match address");

    a_qio_opcode : assert property (
        rd_bus.rd_en && rd_bus.hit && rd_bus.ofs == `OFS_QIO_OPC |=> rd_bus.rdata == 8'hEB
    ) else $error("Quad I/O opcode byte wrong");

    a_density_low : assert property (
        rd_bus.rd_en && rd_bus.hit && rd_bus.ofs inside {`OFS_DEN0, `OFS_DEN1, `OFS_DEN2}
            |=> rd_bus.rdata == 8'hFF
    ) else $error("Density low bytes wrong");

    // Outside the parameter the store answers with fill, never stale data
    a_outside_fill : assert property (
        rd_bus.rd_en && !rd_bus.hit |=> rd_bus.rdata == `PARAM_FILL
    ) else $error("Read outside the parameter not filled");

    // The length byte counts 136 bytes after itself, so 89h is the last wrapped offset
    a_span_last : assert property (
        addr_q == BASE_ADDR + 24'h000089 |-> rd_bus.hit
    ) else $error("Last parameter byte not served");

    a_span_past : assert property (
        addr_q == BASE_ADDR + 24'h00008A |-> !rd_bus.hit
    ) else $error("Parameter runs past its length");

    // A refused opcode keeps the pin released until select rises
    a_skip_silent : assert property (
        state_q == flash_param_pkg::ST_SKIP && !cs_n_s
            |=> state_q == flash_param_pkg::ST_SKIP && !spi_so_oe_o
    ) else $error("Output driven after a refused opcode");

    a_oe_on_data : assert property (
        dummy_done |=> spi_so_oe_o
    ) else $error("Output not driven after the dummy clocks");

    // Most significant bit leaves first on each byte
    a_so_msb_first : assert property (
        fall && in_data && cnt_q == 5'h00 |=> spi_so_o == $past(byte_q[7])
    ) else $error("Byte did not start with its top bit");

    a_cnt_in_byte : assert property (
        in_data |-> cnt_q <= 5'h07
    ) else $error("Bit counter ran past one byte");

    a_frame_abort : assert property (
        cs_n_s |=> cnt_q == 5'h00
    ) else $error("Cut frame left a partial count");

    a_dummy_addr_hold : assert property (
        in_dummy && !dummy_done |=> addr_q == $past(addr_q)
    ) else $error("Address moved during the dummy clocks");

    c_read_taken : cover property (cmd_done && cmd_ok ##1 state_q == flash_param_pkg::ST_ADDR);

    c_first_data : cover property (dummy_done ##1 spi_so_oe_o);

    c_two_bytes : cover property (byte_done ##[1:400] byte_done);

    c_other_cmd : cover property (cmd_done && !cmd_ok ##1 state_q == flash_param_pkg::ST_SKIP);

    c_frame_cut : cover property (cs_n_s && spi_so_oe_o ##1 !spi_so_oe_o);

endmodule

// ---- hdl/flash_param_pkg.sv ----
package flash_param_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CMD   = 3'b001,
        ST_ADDR  = 3'b010,
        ST_DUMMY = 3'b011,
        ST_DATA  = 3'b100,
        ST_SKIP  = 3'b101
    } xfer_state_type;

    typedef logic [7:0]  byte_type;
    typedef logic [23:0] addr_type;

endpackage

// ---- hdl/flash_param_regs.svh ----
`ifndef FLASH_PARAM_REGS_SVH
`define FLASH_PARAM_REGS_SVH

// Serial framing: opcode, 24 address bits, dummy clocks, then data
`define RD_OPCODE      8'h5A
`define CMD_LAST       5'h07
`define ADDR_LAST      5'h17
`define DUMMY_LAST     5'h07
`define BYTE_LAST      3'h7

// Placement in the discoverable address space
`define BFT_SFDP_ADDR  24'h001090
`define WRAP_SHIFT     24'h000002

// Wrapped offsets
`define OFS_ID         8'h00
`define OFS_LEN        8'h01
`define OFS_CAPS       8'h02
`define OFS_ERASE4K    8'h03
`define OFS_DW1B2      8'h04
`define OFS_DW1B3      8'h05
`define OFS_DEN0       8'h06
`define OFS_DEN1       8'h07
`define OFS_DEN2       8'h08
`define OFS_DEN3       8'h09
`define OFS_QIO_CYC    8'h0A
`define OFS_QIO_OPC    8'h0B
`define OFS_QOUT_CYC   8'h0C
`define OFS_QOUT_OPC   8'h0D

// Contents
`define PRM_ID_VAL     8'hA5
`define PRM_LEN_VAL    8'h88
`define CAPS_UNUSED    3'h7
`define CAPS_SR_NV06   2'h0
`define CAPS_BUF_GT64  1'h1
`define CAPS_4K_NONE   2'h3
`define ERASE4K_OPC    8'hFF
`define DW1_BIT23      1'h1
`define DW1_QOUT       1'h0
`define DW1_QIO        1'h1
`define DW1_DIO        1'h1
`define DW1_ADDR_MODE  2'h1
`define DW1_DOUT       1'h0
`define DW1_DDR_BIT    3
`define DW1_TOP        8'hFF
`define DENSITY_BITS   32'h1FFFFFFF
`define QIO_MODE_CYC   3'h2
`define QIO_DUMMY_CYC  5'h08
`define QIO_OPCODE     8'hEB
`define QOUT_MODE_CYC  3'h7
`define QOUT_DUMMY_CYC 5'h1F
`define QOUT_OPCODE    8'hFF
`define PARAM_FILL     8'hFF

`endif

// ---- hdl/param_rom.sv ----
`timescale 1ns/100ps
`include "flash_param_regs.svh"

module param_rom (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rstn_i,
    // Read port
    rom_rd_if.store   bus
);

    localparam logic [31:0] DENSITY = `DENSITY_BITS;

    function automatic logic [7:0] lookup(input logic [7:0] ofs, input logic ddr);
        case (ofs)
            `OFS_ID:       lookup = `PRM_ID_VAL;
            `OFS_LEN:      lookup = `PRM_LEN_VAL;
            `OFS_CAPS:     lookup = {`CAPS_UNUSED, `CAPS_SR_NV06, `CAPS_BUF_GT64,
                                     `CAPS_4K_NONE};
            `OFS_ERASE4K:  lookup = `ERASE4K_OPC;
            `OFS_DW1B2:    lookup = {`DW1_BIT23, `DW1_QOUT, `DW1_QIO, `DW1_DIO, ddr,
                                     `DW1_ADDR_MODE, `DW1_DOUT};
            `OFS_DW1B3:    lookup = `DW1_TOP;
            `OFS_DEN0:     lookup = DENSITY[7:0];
            `OFS_DEN1:     lookup = DENSITY[15:8];
            `OFS_DEN2:     lookup = DENSITY[23:16];
            `OFS_DEN3:     lookup = DENSITY[31:24];
            `OFS_QIO_CYC:  lookup = {`QIO_MODE_CYC, `QIO_DUMMY_CYC};
            `OFS_QIO_OPC:  lookup = `QIO_OPCODE;
            `OFS_QOUT_CYC: lookup = {`QOUT_MODE_CYC, `QOUT_DUMMY_CYC};
            `OFS_QOUT_OPC: lookup = `QOUT_OPCODE;
            default:       lookup = `PARAM_FILL;
        endcase
    endfunction

    wire logic [7:0] tbl_byte = bus.hit ? lookup(bus.ofs, bus.ddr_sel) : `PARAM_FILL;

    logic [7:0] rdata_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_q <= `PARAM_FILL;
        end else if (bus.rd_en) begin
            rdata_q <= tbl_byte;
        end
    end

    assign bus.rdata = rdata_q;

endmodule

// ---- hdl/pin_sync.sv ----
`timescale 1ns/100ps

module pin_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    // Asynchronous levels in, synchronised levels out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_q;

    // The first stage feeds the second stage only
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= RST_VAL;
            q_o    <= RST_VAL;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end

endmodule

// ---- hdl/rom_rd_if.sv ----
`timescale 1ns/100ps

interface rom_rd_if;
    logic                      rd_en;
    logic                      hit;
    logic                      ddr_sel;
    flash_param_pkg::byte_type ofs;
    flash_param_pkg::byte_type rdata;

    modport reader (output rd_en, output hit, output ddr_sel, output ofs, input rdata);
    modport store  (input rd_en, input hit, input ddr_sel, input ofs, output rdata);
endinterface
